// >>> hw/ffr_map.svh
// field positions, reset values and timing counts of the block
`ifndef FFR_MAP_SVH
`define FFR_MAP_SVH

// ****************************************************************
// fan configuration register fields
// ****************************************************************
`define FFR_CFG_RESET      16'h0000
`define FFR_CFG_ZERO_BIT   12
`define FFR_CFG_HYS_MSB    11
`define FFR_CFG_HYS_LSB    10
`define FFR_CFG_SFO_BIT    9
`define FFR_CFG_TFO_BIT    8
`define FFR_CFG_RAMP_MSB   7
`define FFR_CFG_RAMP_LSB   5

// ****************************************************************
// timing
// ****************************************************************
`define FFR_CLK_PERIOD_NS  4
`define FFR_MS_NS          1000000
`define FFR_CYC_PER_MS     (`FFR_MS_NS / `FFR_CLK_PERIOD_NS)
`define FFR_MAN_TIMEOUT_MS 10000
`define FFR_RATE_SLOW_MS   10'd1000
`define FFR_RATE_FAST_MS   10'd200

// ****************************************************************
// duty, speed and hysteresis figures
// ****************************************************************
`define FFR_FULL_DUTY      7'h64
`define FFR_NEAR_STEP      7'h01
`define FFR_DEAD_MUL       20
`define FFR_NEAR_MUL       5
`define FFR_HYS_BASE_C     9'sd2

`endif

// >>> hw/ffr_pkg.sv
// types and shared arithmetic of the fan fault and ramp block
`include "ffr_map.svh"

package ffr_pkg;

    // ****************************************************************
    // ramp table lookups
    // ****************************************************************
    function automatic logic [9:0] ffr_ramp_ms(input logic [2:0] code);
        ffr_ramp_ms = (code < 3'h3) ? `FFR_RATE_SLOW_MS
                                    : `FFR_RATE_FAST_MS;
    endfunction : ffr_ramp_ms

    // code 7 is not tabled; it behaves as code 6
    function automatic logic [6:0] ffr_ramp_step(input logic [2:0] code);
        case (code)
            3'h0, 3'h3: ffr_ramp_step = 7'h01;
            3'h1, 3'h4: ffr_ramp_step = 7'h02;
            3'h2, 3'h5: ffr_ramp_step = 7'h03;
            default:    ffr_ramp_step = 7'h04;
        endcase
    endfunction : ffr_ramp_step

    // moves a duty toward a goal by at most one step, never past the goal
    function automatic logic [6:0] ffr_move(input logic [6:0] cur,
                                            input logic [6:0] goal,
                                            input logic [6:0] step);
        logic [7:0] sum;
        sum = {1'b0, cur} + {1'b0, step};
        if (goal > cur) begin
            ffr_move = (sum[6:0] > goal || sum[7]) ? goal : sum[6:0];
        end else if (goal < cur) begin
            ffr_move = (cur - goal > step) ? cur - step : goal;
        end else begin
            ffr_move = cur;
        end
    endfunction : ffr_move

    // ****************************************************************
    // state types
    // ****************************************************************
    typedef struct packed {
        logic [31:0] count;
        logic        done;
    } ffr_tick_state_type;

    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] man_value;
        logic        man_timeout;
        logic [9:0]  interval_ms;
        logic [6:0]  duty;
        logic        full_duty;
        logic        hold;
        logic        step_down_ok;
    } ffr_state_type;

endpackage : ffr_pkg

// >>> hw/ffr_tick.sv
// cycle counter that pulses once each time it reaches its limit
`timescale 1ns/10ps

module ffr_tick #(
    parameter int LIMIT = 250000
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic ce,
    input  wire logic clear,
    input  wire logic en,
    output logic      done
);
    ffr_pkg::ffr_tick_state_type st;
    ffr_pkg::ffr_tick_state_type next_st;

    always_comb begin
        next_st = st;
        next_st.done = 1'b0;
        if (clear) begin
            next_st.count = 32'h0;
        end else if (en) begin
            if (st.count == 32'(LIMIT - 1)) begin
                next_st.count = 32'h0;
                next_st.done = 1'b1;
            end else begin
                next_st.count = st.count + 32'h1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign done = st.done;
endmodule : ffr_tick

// >>> hw/ffr_hyst.sv
// thermal hysteresis check for stepping down one table level
`timescale 1ns/10ps
`include "ffr_map.svh"

module ffr_hyst (
    input  wire logic signed [7:0] temp,
    input  wire logic signed [7:0] thresh,
    input  wire logic        [1:0] sel,
    output logic                   step_down
);
    logic signed [8:0] margin;
    logic signed [8:0] limit;

    // 2, 4, 6 or 8 degrees
    always_comb begin
        margin = `FFR_HYS_BASE_C + $signed({6'h0, sel, 1'b0});
        limit = $signed({thresh[7], thresh}) - margin;
        step_down = $signed({temp[7], temp}) <= limit;
    end
endmodule : ffr_hyst

// >>> hw/ffr_fan_ctl.sv
// fan fault response, duty ramp limiting and hysteresis, top level
`timescale 1ns/10ps
`include "ffr_map.svh"

// Operation
// - With sensor override clear, sensor faults in auto mode or 10s without a manual write in manual mode ramp to full duty.
// - With sensor override set, sensor faults and the manual write rate are ignored and the last value stays in use.
// - In auto mode with override set, good assigned sensors keep control; with none left the duty is held.
// - Only an invalid sensor reading counts as a sensor fault, never an overtemperature.
// - With tach override clear a fan fault ramps to full duty; with it set a fan fault is ignored.
// - Normal control resumes as soon as the fan fault goes away.
// - The three-bit ramp field sets update interval and step size both up and down, always so in PWM mode.
// - In RPM mode the fan speed is sampled every 200 ms or 1000 ms per the ramp field.
// - In RPM mode within 20% of target each duty change is at most 1%.
// - In RPM mode within 5% of target the duty is left unchanged.
// - The two-bit hysteresis field gives 2, 4, 6 or 8 degrees below a table threshold before stepping down.
module ffr_fan_ctl #(
    parameter int CYC_PER_MS = `FFR_CYC_PER_MS,
    parameter int TIMEOUT_MS = `FFR_MAN_TIMEOUT_MS
) (
    input  wire logic               sys_clk,
    input  wire logic               rst_b,
    input  wire logic               ce,
    input  wire logic               cfg_wr_en,
    input  wire logic        [15:0] cfg_wr_data,
    output logic             [15:0] cfg_rd_data,
    input  wire logic               auto_mode,
    input  wire logic               rpm_mode,
    input  wire logic               man_wr_en,
    input  wire logic        [15:0] man_value,
    input  wire logic        [6:0]  lut_duty,
    input  wire logic        [15:0] lut_rpm,
    input  wire logic        [15:0] tach_rpm,
    input  wire logic               fan_fault,
    input  wire logic        [5:0]  sensor_assigned,
    input  wire logic        [5:0]  sensor_fault,
    input  wire logic signed [7:0]  temp,
    input  wire logic signed [7:0]  lut_thresh,
    output logic             [6:0]  duty,
    output logic                    full_duty,
    output logic                    hold,
    output logic                    step_down_ok
);
    ffr_pkg::ffr_state_type st;
    ffr_pkg::ffr_state_type next_st;

    logic              ms_tick;
    logic              man_expired;
    logic              hys_down;
    logic        [2:0] ramp_code;
    logic              sfo;
    logic              tfo;
    logic        [5:0] bad_sensors;
    logic              any_bad;
    logic              all_bad;
    logic              force_full;
    logic              do_hold;
    logic              update;
    logic        [15:0] goal_rpm;
    logic        [6:0] goal_duty;
    logic        [16:0] rpm_err;
    logic        [21:0] err_dead;
    logic        [21:0] err_near;
    logic        [6:0] step;

    // ****************************************************************
    // time bases
    // ****************************************************************
    ffr_tick #(
        .LIMIT (CYC_PER_MS)
    ) u_ms (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .clear   (1'b0),
        .en      (1'b1),
        .done    (ms_tick)
    );

    // restarted by every manual write and held clear in auto mode
    ffr_tick #(
        .LIMIT (TIMEOUT_MS)
    ) u_man (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .ce      (ce),
        .clear   (man_wr_en | auto_mode),
        .en      (ms_tick),
        .done    (man_expired)
    );

    ffr_hyst u_hyst (
        .temp      (temp),
        .thresh    (lut_thresh),
        .sel       (st.cfg[`FFR_CFG_HYS_MSB:`FFR_CFG_HYS_LSB]),
        .step_down (hys_down)
    );

    // ****************************************************************
    // fault decisions
    // ****************************************************************
    always_comb begin
        ramp_code = st.cfg[`FFR_CFG_RAMP_MSB:`FFR_CFG_RAMP_LSB];
        sfo = st.cfg[`FFR_CFG_SFO_BIT];
        tfo = st.cfg[`FFR_CFG_TFO_BIT];
        // overtemperature is not an input here on purpose
        bad_sensors = sensor_assigned & sensor_fault;
        any_bad = |bad_sensors;
        all_bad = (sensor_assigned != 6'h0)
                  && (bad_sensors == sensor_assigned);
        force_full = 1'b0;
        if (!tfo && fan_fault) begin
            force_full = 1'b1;
        end
        if (!sfo && auto_mode && any_bad) begin
            force_full = 1'b1;
        end
        if (!sfo && !auto_mode && st.man_timeout) begin
            force_full = 1'b1;
        end
        // fan fault outranks a hold; the hold freezes the pre-fault duty
        do_hold = sfo && auto_mode && all_bad && !force_full;
    end

    // ****************************************************************
    // ramp step selection
    // ****************************************************************
    always_comb begin
        goal_rpm = auto_mode ? lut_rpm : st.man_value;
        goal_duty = auto_mode ? lut_duty : st.man_value[6:0];
        if (goal_duty > `FFR_FULL_DUTY) begin
            goal_duty = `FFR_FULL_DUTY;
        end
        if (force_full) begin
            goal_duty = `FFR_FULL_DUTY;
        end
        rpm_err = (tach_rpm > goal_rpm) ? {1'b0, tach_rpm - goal_rpm}
                                        : {1'b0, goal_rpm - tach_rpm};
        err_dead = 22'(rpm_err) * 22'(`FFR_DEAD_MUL);
        err_near = 22'(rpm_err) * 22'(`FFR_NEAR_MUL);
        step = ffr_pkg::ffr_ramp_step(ramp_code);
        if (rpm_mode && !force_full && err_near <= 22'(goal_rpm)) begin
            step = `FFR_NEAR_STEP;
        end
        update = ms_tick
                 && (st.interval_ms + 10'h1
                     >= ffr_pkg::ffr_ramp_ms(ramp_code));
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        if (cfg_wr_en) begin
            next_st.cfg = cfg_wr_data;
            next_st.cfg[`FFR_CFG_ZERO_BIT] = 1'b0;
        end
        if (man_wr_en) begin
            next_st.man_value = man_value;
        end
        // a new expiry wins over a write in the same cycle
        if (man_expired) begin
            next_st.man_timeout = 1'b1;
        end else if (man_wr_en || auto_mode) begin
            next_st.man_timeout = 1'b0;
        end
        if (ms_tick) begin
            next_st.interval_ms = update ? 10'h0 : st.interval_ms + 10'h1;
        end
        if (update && !do_hold) begin
            if (!rpm_mode || force_full) begin
                next_st.duty = ffr_pkg::ffr_move(st.duty, goal_duty,
                                                 step);
            end else if (err_dead <= 22'(goal_rpm)) begin
                next_st.duty = st.duty;
            end else if (tach_rpm < goal_rpm) begin
                next_st.duty = ffr_pkg::ffr_move(st.duty,
                                                 `FFR_FULL_DUTY,
                                                 step);
            end else begin
                next_st.duty = ffr_pkg::ffr_move(st.duty, 7'h00,
                                                 step);
            end
        end
        next_st.full_duty = force_full;
        next_st.hold = do_hold;
        next_st.step_down_ok = auto_mode && hys_down;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.cfg <= `FFR_CFG_RESET;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign cfg_rd_data = st.cfg;
    assign duty = st.duty;
    assign full_duty = st.full_duty;
    assign hold = st.hold;
    assign step_down_ok = st.step_down_ok;
endmodule : ffr_fan_ctl

// >>> test/ffr_fan_model.sv
// behavioural fan: tach speed follows duty, stall on command
`timescale 1ns/10ps

module ffr_fan_model #(
    parameter int RPM_PER_PCT = 20
) (
    input  wire logic [6:0]  duty,
    input  wire logic        stall,
    output logic      [15:0] tach_rpm,
    output logic             fan_fault
);
    // ****************************************************************
    // speed and fault
    // ****************************************************************
    // a stalled fan reports no speed at all, never the last one
    assign tach_rpm  = stall ? 16'h0000 : 16'(duty) * 16'(RPM_PER_PCT);
    assign fan_fault = stall;
endmodule : ffr_fan_model

// >>> test/ffr_fan_ctl_props.sv
// assertion checker for the fan fault and ramp block
`timescale 1ns/10ps

module ffr_fan_ctl_props (
    input wire logic               sys_clk,
    input wire logic               rst_b,
    input wire logic               ce,
    input wire logic               cfg_wr_en,
    input wire logic        [15:0] cfg_wr_data,
    input wire logic        [15:0] cfg_rd_data,
    input wire logic               auto_mode,
    input wire logic               fan_fault,
    input wire logic        [5:0]  sensor_assigned,
    input wire logic        [5:0]  sensor_fault,
    input wire logic signed [7:0]  temp,
    input wire logic signed [7:0]  lut_thresh,
    input wire logic        [6:0]  duty,
    input wire logic               full_duty,
    input wire logic               hold,
    input wire logic               step_down_ok
);
    // ****************************************************************
    // helpers
    // ****************************************************************
    logic signed [9:0] lim;
    logic signed [9:0] t10;
    logic              sd_exp;
    logic              bad;
    logic              all_bad;
    logic              cmd;
    assign lim = {{2{lut_thresh[7]}}, lut_thresh}
                 - {7'h00, cfg_rd_data[11:10], 1'b0} - 10'h002;
    assign t10     = {{2{temp[7]}}, temp};
    assign sd_exp  = auto_mode && (t10 <= lim);
    assign bad     = |(sensor_fault & sensor_assigned);
    assign all_bad = |sensor_assigned
                     && ((sensor_fault & sensor_assigned) == sensor_assigned);
    // a config write in the same cycle would change the fields seen
    assign cmd     = ce && !cfg_wr_en;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    property p_cfg_wr;
        ce && cfg_wr_en |=> cfg_rd_data == ($past(cfg_wr_data) & 16'hefff);
    endproperty
    a_cfg_wr: assert property (p_cfg_wr) else $error("config readback");
    property p_fan_force;
        cmd && fan_fault && !cfg_rd_data[8] |=> full_duty;
    endproperty
    a_fan_force: assert property (p_fan_force) else $error("fan force");
    property p_fan_clear;
        cmd && auto_mode && !fan_fault && !bad |=> !full_duty;
    endproperty
    a_fan_clear: assert property (p_fan_clear) else $error("fan clear");
    property p_sens_force;
        cmd && auto_mode && !cfg_rd_data[9] && bad |=> full_duty;
    endproperty
    a_sens_force: assert property (p_sens_force) else $error("sensor");
    property p_hold;
        cmd && auto_mode && cfg_rd_data[9] && !fan_fault && all_bad |=> hold;
    endproperty
    a_hold: assert property (p_hold) else $error("hold missing");
    property p_freeze;
        hold && $past(hold) |-> $stable(duty);
    endproperty
    a_freeze: assert property (p_freeze) else $error("duty moved");
    property p_step;
        (duty > $past(duty) ? duty - $past(duty) : $past(duty) - duty) <= 7'h04;
    endproperty
    a_step: assert property (p_step) else $error("step too big");
    property p_cap;
        duty <= 7'h64;
    endproperty
    a_cap: assert property (p_cap) else $error("duty above full");
    property p_step_down;
        cmd |=> step_down_ok == $past(sd_exp);
    endproperty
    a_step_down: assert property (p_step_down) else $error("hysteresis");
endmodule : ffr_fan_ctl_props

bind ffr_fan_ctl ffr_fan_ctl_props u_props (
    .sys_clk         (sys_clk),
    .rst_b           (rst_b),
    .ce              (ce),
    .cfg_wr_en       (cfg_wr_en),
    .cfg_wr_data     (cfg_wr_data),
    .cfg_rd_data     (cfg_rd_data),
    .auto_mode       (auto_mode),
    .fan_fault       (fan_fault),
    .sensor_assigned (sensor_assigned),
    .sensor_fault    (sensor_fault),
    .temp            (temp),
    .lut_thresh      (lut_thresh),
    .duty            (duty),
    .full_duty       (full_duty),
    .hold            (hold),
    .step_down_ok    (step_down_ok)
);

// >>> test/ffr_fan_ctl_tb_top.sv
// self-checking bench for the fan fault and ramp block
`timescale 1ns/10ps

module ffr_fan_ctl_tb_top;
    typedef struct packed {
        logic [15:0] cfg;
        logic [7:0]  tmp;
        logic        sd;
    } ffr_row_type;
    logic sys_clk = 0, rst_b = 0, ce = 1, cfg_wr_en = 0, auto_mode = 1;
    logic rpm_mode = 0, man_wr_en = 0, stall = 0, fan_fault, ok;
    logic full_duty, hold, step_down_ok;
    logic [15:0] cfg_wr_data = 0, man_value = 0, cfg_rd_data, tach_rpm;
    logic [5:0] sensor_assigned = 0, sensor_fault = 0;
    logic signed [7:0] temp = 0, lut_thresh = 8'sd40;
    logic [6:0] duty, old;
    logic [6:0] lut_duty = 7'h1e;
    logic [15:0] lut_rpm = 16'h0000;
    int num_errors = 0, num_checks = 0;
    int waited = 0, n_moves = 0;
    int steps[7] = '{1, 2, 3, 1, 2, 3, 4};
    ffr_row_type rows[8] = '{'{16'h1000, 38, 1}, '{16'h0000, 39, 0},
        '{16'h0400, 36, 1}, '{16'h0400, 37, 0}, '{16'h0800, 34, 1},
        '{16'h0800, 35, 0}, '{16'h0c00, 32, 1}, '{16'hffff, 33, 0}};

    always #2 sys_clk = ~sys_clk;
    ffr_fan_model u_fan (.duty(duty), .stall(stall), .tach_rpm(tach_rpm),
        .fan_fault(fan_fault));
    ffr_fan_ctl #(.CYC_PER_MS(4), .TIMEOUT_MS(5)) uut (.sys_clk(sys_clk),
        .rst_b(rst_b), .ce(ce), .cfg_wr_en(cfg_wr_en),
        .cfg_wr_data(cfg_wr_data), .cfg_rd_data(cfg_rd_data),
        .auto_mode(auto_mode), .rpm_mode(rpm_mode), .man_wr_en(man_wr_en),
        .man_value(man_value), .lut_duty(lut_duty), .lut_rpm(lut_rpm),
        .tach_rpm(tach_rpm), .fan_fault(fan_fault),
        .sensor_assigned(sensor_assigned), .sensor_fault(sensor_fault),
        .temp(temp), .lut_thresh(lut_thresh), .duty(duty),
        .full_duty(full_duty), .hold(hold), .step_down_ok(step_down_ok));

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr_cfg(input logic [15:0] d);
        cfg_wr_en = 1;
        cfg_wr_data = d;
        @(negedge sys_clk);
        cfg_wr_en = 0;
        @(negedge sys_clk);
    endtask : wr_cfg
    task automatic man_wr(input logic [15:0] v);
        man_wr_en = 1;
        man_value = v;
        @(negedge sys_clk);
        man_wr_en = 0;
    endtask : man_wr
    task automatic wait_chg(input int max);
        old = duty;
        ok = 0;
        waited = 0;
        repeat (max) begin
            @(negedge sys_clk);
            waited++;
            if (duty !== old) begin
                ok = 1;
                break;
            end
        end
    endtask : wait_chg
    task automatic complete_run;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    initial begin
        repeat (100000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end

    initial begin
        repeat (3) @(negedge sys_clk);
        chk("cfg_reset", 16'h0000, cfg_rd_data);
        rst_b = 1;
        @(negedge sys_clk);
        foreach (rows[i]) begin
            temp = rows[i].tmp;
            wr_cfg(rows[i].cfg);
            chk("cfg_rd", rows[i].cfg & 16'hefff, cfg_rd_data);
            chk("step_down", 16'(rows[i].sd), 16'(step_down_ok));
        end
        // ramp steps per code, sensor override on to keep timeout away
        auto_mode = 0;
        man_wr(16'h0064);
        for (int c = 0; c < 7; c++) begin
            wr_cfg(16'h0200 | 16'(c << 5));
            wait_chg(9000);
            chk("ramp_step", 16'(steps[c]), 16'(duty - old));
        end
        chk("no_timeout", 16'h0000, 16'(full_duty));
        stall = 1;
        repeat (2) @(negedge sys_clk);
        chk("fan_force", 16'h0001, 16'(full_duty));
        stall = 0;
        repeat (2) @(negedge sys_clk);
        chk("fan_clear", 16'h0000, 16'(full_duty));
        wr_cfg(16'h03c0);
        stall = 1;
        repeat (2) @(negedge sys_clk);
        chk("fan_ignored", 16'h0000, 16'(full_duty));
        stall = 0;
        wr_cfg(16'h00c0);
        repeat (12) begin
            man_wr(16'h0064);
            repeat (6) @(negedge sys_clk);
            chk("man_kept", 16'h0000, 16'(full_duty));
        end
        repeat (40) @(negedge sys_clk);
        chk("man_timeout", 16'h0001, 16'(full_duty));
        auto_mode = 1;
        sensor_assigned = 6'h03;
        sensor_fault = 6'h01;
        repeat (2) @(negedge sys_clk);
        chk("sens_force", 16'h0001, 16'(full_duty));
        wr_cfg(16'h02c0);
        chk("sens_ignored", 16'h0000, 16'({full_duty, hold}));
        sensor_fault = 6'h03;
        repeat (2) @(negedge sys_clk);
        chk("hold", 16'h0001, 16'(hold));
        wait_chg(2000);
        chk("held", 16'h0000, 16'(ok));
        sensor_fault = 0;
        // rpm target 1000 with 20 rpm per percent settles at duty 48..52
        auto_mode = 0;
        rpm_mode = 1;
        man_wr(16'd1000);
        repeat (80) begin
            wait_chg(2000);
            if (!ok) break;
            // ramp code 6 samples every 200 ms of 4 cycles each
            if (n_moves > 0)
                chk("rpm_interval", 16'd800, 16'(waited));
            n_moves++;
            if (old >= 40 && old <= 60)
                chk("near_step", 16'h0001,
                    16'(duty - old + 7'h01 <= 7'h02));
        end
        chk("dead_zone", 16'h0001, 16'(duty >= 48 && duty <= 52));
        complete_run();
    end
endmodule : ffr_fan_ctl_tb_top
